// >>> src/energy_pulse_output_config.sv
/*
 * Pulse output configuration bank: overcurrent status, pulse pin disables,
 * energy type and phase selection, frequency converter, line frequency and
 * phase B current derivation.
 * Assumes the serial port decoder presents one-cycle rd/wr strobes on clk
 * and that energy, current and overcurrent inputs are synchronous to clk.
 */
// Notes on behaviour
// [R1] Overcurrent status reads a 4-bit flag field: A, B, C, neutral.
// [R2] Disable bit for output 4 stops it and holds its pin high.
// [R3] A disabled output never raises its main status pulse flag.
// [R4] Outputs 3, 2, 1 have disable bits 14, 13, 12, same behaviour.
// [R5] Output 4 energy type at bits 11:9; codes 000 and 110 mean total active.
// [R6] Codes 001 to 101 pick reactive, apparent, fundamental kinds; 111 reserved.
// [R7] Energy types of outputs 3, 2, 1 sit at bits 8:6, 5:3, 2:0.
// [R8] Output 4 phase inclusion at 11:9: bit 2 C, bit 1 B, bit 0 A.
// [R9] Outputs 3, 2, 1 phase inclusion at bits 8:6, 5:3, 2:0.
// [R10] Each output integrates the selected energy summed over included phases.
// [R11] Bit 8 picks 50 Hz when 0, 60 Hz when 1, for fundamental measurements.
// [R12] Without zero crossings the default line period follows that frequency bit.
// [R13] Bit 7 set makes phase B current the negated sum of A and C.
// [R14] Accumulator clear empties converter and denominator count, then self-clears.
`timescale 1ns/10ps

module energy_pulse_output_config
(
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              nrst,
    // Register access from serial port
    input  wire pulse_cfg_pkg::reg_req_type        reg_req,
    output logic [15:0]                            reg_rdata,
    output logic                                   reg_rvalid,
    // Metrology inputs
    input  wire logic [3:0]                        overcurrent_phase_flags,
    input  wire pulse_cfg_pkg::energy_in_type      energy_in,
    input  wire logic signed [15:0]                current_a,
    input  wire logic signed [15:0]                current_b,
    input  wire logic signed [15:0]                current_c,
    input  wire logic                              pulse_accumulator_clear,
    // Pulse pins and status
    output logic [3:0]                             pulse_pin,
    output logic [3:0]                             pulse_flag,
    // Derived measurements
    output logic signed [16:0]                     phase_b_current,
    output logic                                   line_frequency_select,
    output logic [15:0]                            default_line_period
);

    pulse_cfg_pkg::block_state_type state;
    pulse_cfg_pkg::block_state_type next_state;
    // One array element per output, since each is filled by its own process
    logic [17:0]                     sel_energy [4];

    // Maps an energy type code to its index; reserved code gives no index
    function automatic logic [3:0] energy_index(input logic [2:0] code);
        logic [3:0] idx;
        idx = 4'hf;
        case (code)
            pulse_cfg_pkg::ENERGY_TOTAL_ACTIVE:     idx = 4'h0; // [R5]
            pulse_cfg_pkg::ENERGY_TOTAL_ACTIVE_ALT: idx = 4'h0; // [R5]
            pulse_cfg_pkg::ENERGY_TOTAL_REACTIVE:   idx = 4'h1; // [R6]
            pulse_cfg_pkg::ENERGY_TOTAL_APPARENT:   idx = 4'h2; // [R6]
            pulse_cfg_pkg::ENERGY_FUND_ACTIVE:      idx = 4'h3; // [R6]
            pulse_cfg_pkg::ENERGY_FUND_REACTIVE:    idx = 4'h4; // [R6]
            pulse_cfg_pkg::ENERGY_FUND_APPARENT:    idx = 4'h5; // [R6]
            default:                                idx = 4'hf; // [R6]
        endcase
        return idx;
    endfunction

    // Selected energy summed over included phases, one per output
    for (genvar o = 0; o < pulse_cfg_pkg::OUTPUTS; o++)
    begin : g_sum
        logic [2:0] etype;
        logic [2:0] incl;
        logic [3:0] eidx;
        assign etype = state.mode[o*pulse_cfg_pkg::FIELD_W +: pulse_cfg_pkg::FIELD_W]; // [R7]
        assign incl  = state.phase_sel[o*pulse_cfg_pkg::FIELD_W +: pulse_cfg_pkg::FIELD_W]; // [R9]
        assign eidx  = energy_index(etype);
        always_comb
        begin
            sel_energy[o] = 18'h00000;
            if (eidx < 4'(pulse_cfg_pkg::ENERGY_TYPES))
            begin
                for (int p = 0; p < pulse_cfg_pkg::PHASES; p++)
                begin
                    if (incl[p]) // [R8]
                    begin
                        sel_energy[o] = sel_energy[o] + 18'(energy_in.value[eidx[2:0]][p]); // [R10]
                    end
                end
            end
        end
    end

    // Next state: register file, converter and derived outputs
    always_comb
    begin
        logic [24:0] sum;
        logic        dis;
        sum        = 25'h0000000;
        dis        = 1'b0;
        next_state = state;
        next_state.overcurrent = overcurrent_phase_flags; // [R1]
        next_state.rvalid      = 1'b0;

        if (reg_req.wr)
        begin
            case (reg_req.addr)
                pulse_cfg_pkg::PULSE_OUTPUT_MODE_ADDR:
                    next_state.mode = reg_req.wdata & pulse_cfg_pkg::PULSE_OUTPUT_MODE_MASK;
                pulse_cfg_pkg::PULSE_PHASE_SELECTION_ADDR:
                    next_state.phase_sel = reg_req.wdata
                                         & pulse_cfg_pkg::PULSE_PHASE_SELECTION_MASK;
                pulse_cfg_pkg::ACCUMULATION_MODE_ADDR:
                    next_state.acc_mode = reg_req.wdata & pulse_cfg_pkg::ACCUMULATION_MODE_MASK;
                default:
                    next_state.rvalid = 1'b0; // Read-only or unmapped: ignored
            endcase
        end

        // Reads answer one cycle later; reserved and unmapped read zero
        if (reg_req.rd)
        begin
            next_state.rvalid = 1'b1;
            case (reg_req.addr)
                pulse_cfg_pkg::OVERCURRENT_PHASE_STATUS_ADDR:
                    next_state.rdata = {12'h000, state.overcurrent}; // [R1]
                pulse_cfg_pkg::PULSE_OUTPUT_MODE_ADDR:
                    next_state.rdata = state.mode;
                pulse_cfg_pkg::PULSE_PHASE_SELECTION_ADDR:
                    next_state.rdata = state.phase_sel;
                pulse_cfg_pkg::ACCUMULATION_MODE_ADDR:
                    next_state.rdata = state.acc_mode;
                default:
                    next_state.rdata = 16'h0000;
            endcase
        end

        // Frequency converters; pulse keeps accumulating while the pin is low
        next_state.flag = 4'h0;
        for (int o = 0; o < pulse_cfg_pkg::OUTPUTS; o++)
        begin
            dis = state.mode[pulse_cfg_pkg::DISABLE_LSB + o]; // [R4]
            sum = {1'b0, state.acc[o]} + {7'h00, sel_energy[o]}; // [R10]
            case (state.pstate[o])
                pulse_cfg_pkg::PULSE_IDLE:
                begin
                    next_state.pin[o] = 1'b1;
                    if (sum >= {1'b0, pulse_cfg_pkg::PULSE_DENOMINATOR})
                    begin
                        sum = sum - {1'b0, pulse_cfg_pkg::PULSE_DENOMINATOR};
                        next_state.flag[o]    = !dis; // [R3]
                        next_state.pin[o]     = dis; // [R2]
                        next_state.pstate[o]  = pulse_cfg_pkg::PULSE_LOW;
                        next_state.low_cnt[o] = 4'(pulse_cfg_pkg::PULSE_LOW_CYCLES - 1);
                    end
                end
                pulse_cfg_pkg::PULSE_LOW:
                begin
                    next_state.pin[o] = dis; // [R2]
                    if (state.low_cnt[o] == 4'h0)
                    begin
                        next_state.pstate[o] = pulse_cfg_pkg::PULSE_IDLE;
                        next_state.pin[o]    = 1'b1;
                    end
                    else
                    begin
                        next_state.low_cnt[o] = state.low_cnt[o] - 4'h1;
                    end
                end
                default:
                begin
                    next_state.pstate[o] = pulse_cfg_pkg::PULSE_IDLE;
                    next_state.pin[o]    = 1'b1;
                end
            endcase
            // Saturate rather than wrap, also when an idle crossing leaves a large rest
            if (sum > {1'b0, 24'hffffff})
            begin
                sum = {1'b0, 24'hffffff};
            end
            next_state.acc[o] = sum[23:0];
        end

        // Self-clearing accumulator clear: flag then empty the converters
        if (state.clear_pending)
        begin
            next_state.acc           = '0; // [R14]
            next_state.clear_pending = 1'b0; // [R14]
        end
        if (pulse_accumulator_clear)
        begin
            next_state.clear_pending = 1'b1; // [R14]
        end

        // Line frequency and its default line period
        next_state.line_60hz = state.acc_mode[pulse_cfg_pkg::LINE_FREQ_BIT]; // [R11]
        next_state.line_period = state.acc_mode[pulse_cfg_pkg::LINE_FREQ_BIT]
                               ? pulse_cfg_pkg::LINE_PERIOD_60HZ
                               : pulse_cfg_pkg::LINE_PERIOD_50HZ; // [R12]

        // Phase B current, measured or derived from A and C
        if (state.acc_mode[pulse_cfg_pkg::DERIVE_B_BIT])
        begin
            next_state.phase_b = -17'(current_a) - 17'(current_c); // [R13]
        end
        else
        begin
            next_state.phase_b = 17'(current_b);
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state             <= '0;
            state.mode        <= pulse_cfg_pkg::PULSE_OUTPUT_MODE_RESET;
            state.phase_sel   <= pulse_cfg_pkg::PULSE_PHASE_SELECTION_RESET;
            state.acc_mode    <= pulse_cfg_pkg::ACCUMULATION_MODE_RESET;
            state.pstate      <= '{default: pulse_cfg_pkg::PULSE_IDLE};
            state.pin         <= 4'hf;
            state.line_period <= pulse_cfg_pkg::LINE_PERIOD_50HZ;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata             = state.rdata;
    assign reg_rvalid            = state.rvalid;
    assign pulse_pin             = state.pin;
    assign pulse_flag            = state.flag;
    assign phase_b_current       = state.phase_b;
    assign line_frequency_select = state.line_60hz;
    assign default_line_period   = state.line_period;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    logic [17:0] total_active_sum;
    always_comb
    begin
        total_active_sum = 18'h00000;
        for (int p = 0; p < pulse_cfg_pkg::PHASES; p++)
        begin
            if (state.phase_sel[9 + p])
            begin
                total_active_sum = total_active_sum + 18'(energy_in.value[0][p]);
            end
        end
    end

    property p_oc_read;
        reg_req.rd && reg_req.addr == pulse_cfg_pkg::OVERCURRENT_PHASE_STATUS_ADDR
        |=> reg_rvalid && reg_rdata == {12'h000, $past(overcurrent_phase_flags, 2)};
    endproperty
    a_oc_read: assert property (p_oc_read) // [R1]
        else $error("overcurrent status read mismatch");

    property p_out4_high;
        state.mode[15] |=> pulse_pin[3];
    endproperty
    a_out4_high: assert property (p_out4_high) // [R2]
        else $error("disabled output 4 pin not high");

    property p_no_flag;
        1'b1 |=> (pulse_flag & $past(state.mode[15:12])) == 4'h0;
    endproperty
    a_no_flag: assert property (p_no_flag) // [R3]
        else $error("pulse flag raised on disabled output");

    property p_pins_high;
        1'b1 |=> (pulse_pin & $past(state.mode[15:12])) == $past(state.mode[15:12]);
    endproperty
    a_pins_high: assert property (p_pins_high) // [R4]
        else $error("disabled pin driven low");

    property p_alt_code;
        (state.mode[11:9] == 3'h6 || state.mode[11:9] == 3'h0)
        |-> sel_energy[3] == total_active_sum;
    endproperty
    a_alt_code: assert property (p_alt_code) // [R5]
        else $error("total active selection mismatch");

    property p_reserved;
        state.mode[11:9] == 3'h7 || state.phase_sel[11:9] == 3'h0 |-> sel_energy[3] == 18'h0;
    endproperty
    a_reserved: assert property (p_reserved) // [R8]
        else $error("energy from reserved code or no phase");

    property p_freq;
        1'b1 |=> line_frequency_select == $past(state.acc_mode[8])
              && default_line_period == ($past(state.acc_mode[8])
                 ? pulse_cfg_pkg::LINE_PERIOD_60HZ : pulse_cfg_pkg::LINE_PERIOD_50HZ);
    endproperty
    a_freq: assert property (p_freq) // [R12]
        else $error("line frequency or default period mismatch");

    property p_derive_b;
        state.acc_mode[7] |=> phase_b_current == -17'($past(current_a)) - 17'($past(current_c));
    endproperty
    a_derive_b: assert property (p_derive_b) // [R13]
        else $error("derived phase B current wrong");

    sequence s_clear_seen;
        pulse_accumulator_clear ##1 (state.clear_pending && !pulse_accumulator_clear);
    endsequence
    property p_clear;
        s_clear_seen |=> state.acc == '0 && !state.clear_pending;
    endproperty
    a_clear: assert property (p_clear) // [R14]
        else $error("accumulator clear did not take effect");

endmodule

// >>> include/pulse_cfg_pkg.sv
/*
 * Constants, types and state layout of the pulse output configuration bank.
 * Assumes a single 25 MHz system clock shared by every user of this package.
 */
package pulse_cfg_pkg;

    // Register offsets as seen by the serial port decoder
    localparam logic [11:0] OVERCURRENT_PHASE_STATUS_ADDR = 12'h48f;
    localparam logic [11:0] PULSE_OUTPUT_MODE_ADDR        = 12'h490;
    localparam logic [11:0] PULSE_PHASE_SELECTION_ADDR    = 12'h491;
    localparam logic [11:0] ACCUMULATION_MODE_ADDR        = 12'h492;

    // Reset values
    localparam logic [15:0] PULSE_OUTPUT_MODE_RESET     = 16'h0000;
    localparam logic [15:0] PULSE_PHASE_SELECTION_RESET = 16'h0000;
    localparam logic [15:0] ACCUMULATION_MODE_RESET     = 16'h0000;

    // Writable bits; everything else reads as zero
    localparam logic [15:0] PULSE_OUTPUT_MODE_MASK     = 16'hffff;
    localparam logic [15:0] PULSE_PHASE_SELECTION_MASK = 16'h0fff;
    localparam logic [15:0] ACCUMULATION_MODE_MASK     = 16'h0180;

    // Field positions
    localparam int OUTPUTS          = 4;
    localparam int PHASES           = 3;
    localparam int ENERGY_TYPES     = 6;
    localparam int FIELD_W          = 3;
    localparam int DISABLE_LSB      = 12;
    localparam int LINE_FREQ_BIT    = 8;
    localparam int DERIVE_B_BIT     = 7;
    localparam int OVERCURRENT_W    = 4;

    // Energy type codes
    localparam logic [2:0] ENERGY_TOTAL_ACTIVE      = 3'h0;
    localparam logic [2:0] ENERGY_TOTAL_REACTIVE    = 3'h1;
    localparam logic [2:0] ENERGY_TOTAL_APPARENT    = 3'h2;
    localparam logic [2:0] ENERGY_FUND_ACTIVE       = 3'h3;
    localparam logic [2:0] ENERGY_FUND_REACTIVE     = 3'h4;
    localparam logic [2:0] ENERGY_FUND_APPARENT     = 3'h5;
    localparam logic [2:0] ENERGY_TOTAL_ACTIVE_ALT  = 3'h6;

    // Frequency converter
    localparam logic [23:0] PULSE_DENOMINATOR = 24'h001000;
    localparam int CLK_PERIOD_NS    = 40;
    localparam int PULSE_LOW_NS     = 320;
    localparam int PULSE_LOW_CYCLES = (PULSE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Default line period in samples when no zero crossing is seen
    localparam int LINE_SAMPLE_RATE_HZ = 8000;
    localparam int LINE_50HZ           = 50;
    localparam int LINE_60HZ           = 60;
    localparam logic [15:0] LINE_PERIOD_50HZ = 16'(LINE_SAMPLE_RATE_HZ / LINE_50HZ);
    localparam logic [15:0] LINE_PERIOD_60HZ = 16'(LINE_SAMPLE_RATE_HZ / LINE_60HZ);

    typedef enum logic [1:0]
    {
        PULSE_IDLE = 2'b01,
        PULSE_LOW  = 2'b10
    } pulse_state_type;

    // Register access request from the serial port decoder
    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [15:0] wdata;
    } reg_req_type;

    // Per-phase energy increments, indexed by type then phase
    typedef struct packed
    {
        logic [5:0][2:0][15:0] value;
    } energy_in_type;

    typedef struct packed
    {
        logic [15:0]                 mode;
        logic [15:0]                 phase_sel;
        logic [15:0]                 acc_mode;
        logic [3:0]                  overcurrent;
        logic [3:0][23:0]            acc;
        pulse_state_type [3:0]       pstate;
        logic [3:0][3:0]             low_cnt;
        logic [3:0]                  pin;
        logic [3:0]                  flag;
        logic [15:0]                 rdata;
        logic                        rvalid;
        logic signed [16:0]          phase_b;
        logic                        clear_pending;
        logic                        line_60hz;
        logic [15:0]                 line_period;
    } block_state_type;

endpackage

// >>> testbench/host_model.sv
/*
 * Host side of the register port: one-cycle read and write strobes.
 * Assumes the bank answers a read with rvalid one cycle after the strobe.
 */
`timescale 1ns/10ps

module host_model
(
    // Clock
    input  wire logic                        clk,
    // Register port
    output pulse_cfg_pkg::reg_req_type       reg_req,
    input  wire logic [15:0]                 reg_rdata,
    input  wire logic                        reg_rvalid
);
    // Idle until the bench asks for a transfer
    initial reg_req = '0;

    // Write strobe for one cycle; stale data is scrambled so it is never reused
    task automatic write_reg(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_req.wr    <= 1'b1;
        reg_req.addr  <= a;
        reg_req.wdata <= d;
        @(posedge clk);
        reg_req.wr    <= 1'b0;
        reg_req.wdata <= ~d;
    endtask

    // Read strobe for one cycle, answer taken at the edge where it still stands
    task automatic read_reg(input logic [11:0] a, output logic [15:0] d, output logic ok);
        @(posedge clk);
        reg_req.rd   <= 1'b1;
        reg_req.addr <= a;
        @(posedge clk);
        reg_req.rd <= 1'b0;
        @(posedge clk);
        ok = reg_rvalid;
        d = reg_rdata;
    endtask
endmodule

// >>> testbench/energy_pulse_output_config_tb.sv
/*
 * Self-checking bench of the pulse output configuration bank.
 * Assumes host_model drives the register port; energy inputs come from here.
 */
`timescale 1ns/10ps

module energy_pulse_output_config_tb;
    logic                         clk;
    logic                         nrst;
    pulse_cfg_pkg::reg_req_type   req;
    logic [15:0]                  rdata;
    logic                         rvalid;
    logic [3:0]                   oc_flags;
    pulse_cfg_pkg::energy_in_type energy;
    logic signed [15:0]           cur_a;
    logic signed [15:0]           cur_b;
    logic signed [15:0]           cur_c;
    logic                         acc_clear;
    logic [3:0]                   pin;
    logic [3:0]                   flag;
    logic signed [16:0]           b_cur;
    logic                         freq_sel;
    logic [15:0]                  period;
    int                           mismatches;
    int                           n_compared;

    energy_pulse_output_config dut
    (
        .clk(clk), .nrst(nrst), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .overcurrent_phase_flags(oc_flags), .energy_in(energy), .current_a(cur_a),
        .current_b(cur_b), .current_c(cur_c), .pulse_accumulator_clear(acc_clear),
        .pulse_pin(pin), .pulse_flag(flag), .phase_b_current(b_cur),
        .line_frequency_select(freq_sel), .default_line_period(period)
    );

    host_model host
    (
        .clk(clk), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid)
    );

    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [16:0] got, input logic [16:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rd_expect(input logic [11:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        host.read_reg(a, d, ok);
        check(17'(ok), 17'h1, "read valid");
        check(17'(d), 17'(exp), "read data");
    endtask

    // Quiet the converters, empty them, then load a fresh setup
    task automatic prep(input logic [15:0] mode, input logic [15:0] sel, input int k,
                        input int p, input logic [15:0] amt);
        energy <= '0;
        repeat (10) @(posedge clk);
        acc_clear <= 1'b1;
        @(posedge clk);
        acc_clear <= 1'b0;
        repeat (12) @(posedge clk);
        host.write_reg(12'h490, mode);
        host.write_reg(12'h491, sel);
        @(posedge clk);
        energy.value[k][p] <= amt;
    endtask

    // Which outputs flag and go low; each low run must last the full width
    task automatic measure(input logic [3:0] exp_mask, input int cycles);
        logic [3:0] fseen;
        logic [3:0] lseen;
        int run [4];
        fseen = '0;
        lseen = '0;
        run = '{default: 0};
        repeat (cycles)
        begin
            // Sampled at the edge, so stimulus after this task stays edge aligned
            @(posedge clk);
            for (int i = 0; i < 4; i++)
            begin
                if (flag[i] === 1'b1)
                begin
                    fseen[i] = 1'b1;
                    check(17'(pin[i]), 17'h0, "pin low with flag");
                end
                if (pin[i] === 1'b0)
                begin
                    lseen[i] = 1'b1;
                    run[i]++;
                end
                else
                begin
                    if (run[i] != 0)
                        check(17'(run[i]), 17'(pulse_cfg_pkg::PULSE_LOW_CYCLES), "low run");
                    run[i] = 0;
                end
            end
        end
        check(17'(fseen), 17'(exp_mask), "flag mask");
        check(17'(lseen), 17'(exp_mask), "pin mask");
    endtask

    task automatic test_reset;
        #1;
        check(17'(pin), 17'hf, "idle pins");
        check(17'(period), 17'(pulse_cfg_pkg::LINE_PERIOD_50HZ), "period");
        for (int a = 'h48f; a <= 'h493; a++)
            rd_expect(12'(a), 16'h0000);
    endtask

    task automatic test_regs;
        for (int a = 'h48f; a <= 'h493; a++)
            host.write_reg(12'(a), 16'hffff);
        rd_expect(12'h490, 16'hffff);
        rd_expect(12'h491, 16'h0fff);
        rd_expect(12'h492, 16'h0180);
        rd_expect(12'h48f, 16'h0000);
        rd_expect(12'h493, 16'h0000);
        host.write_reg(12'h492, 16'h0000);
    endtask

    task automatic test_overcurrent;
        for (int i = 0; i < 4; i++)
        begin
            oc_flags <= 4'(1 << i);
            repeat (3) @(posedge clk);
            rd_expect(12'h48f, 16'(1 << i));
        end
        oc_flags <= 4'h0;
    endtask

    // Every code; outputs 3 and 2 get a type that carries no energy
    task automatic test_types;
        logic [2:0] c;
        logic [2:0] o;
        for (int n = 0; n < 8; n++)
        begin
            c = 3'(n);
            o = (n == 1) ? 3'h2 : 3'h1;
            prep({4'h0, c, o, o, c}, 16'h0fff, (n >= 6) ? 0 : n, 0, 16'h0400);
            measure((n == 7) ? 4'h0 : 4'h9, 40);
        end
    endtask

    task automatic test_phases;
        logic [3:0] exp [3];
        exp = '{4'h1, 4'ha, 4'hc};
        for (int p = 0; p < 3; p++)
        begin
            prep(16'h0000, {4'h0, 3'b110, 3'b100, 3'b010, 3'b001}, 0, p, 16'h0400);
            measure(exp[p], 40);
        end
    endtask

    task automatic test_disable;
        for (int i = 0; i < 4; i++)
        begin
            prep({4'(1 << i), 12'h000}, 16'h0249, 0, 0, 16'h0400);
            measure(~4'(1 << i), 40);
        end
    endtask

    // Five eighths of a denominator, clear, five eighths again: no pulse unless the clear failed
    task automatic test_clear;
        prep(16'h0000, 16'h0249, 0, 0, 16'h0100);
        measure(4'h0, 10);
        energy <= '0;
        acc_clear <= 1'b1;
        @(posedge clk);
        acc_clear <= 1'b0;
        repeat (3) @(posedge clk);
        energy.value[0][0] <= 16'h0100;
        measure(4'h0, 10);
        measure(4'hf, 12);
    endtask

    task automatic test_derived;
        cur_a <= 16'sd100;
        cur_b <= 16'sd55;
        cur_c <= -16'sd30;
        host.write_reg(12'h492, 16'h0180);
        repeat (3) @(posedge clk);
        #1;
        check(17'(freq_sel), 17'h1, "60 Hz");
        check(17'(period), 17'(pulse_cfg_pkg::LINE_PERIOD_60HZ), "period");
        check(b_cur, -17'sd70, "derived b");
        host.write_reg(12'h492, 16'h0000);
        repeat (3) @(posedge clk);
        #1;
        check(17'(freq_sel), 17'h0, "50 Hz");
        check(17'(period), 17'(pulse_cfg_pkg::LINE_PERIOD_50HZ), "period");
        check(b_cur, 17'sd55, "measured b");
    endtask

    task automatic test_done;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        mismatches = 0;
        n_compared = 0;
        nrst = 1'b0;
        oc_flags = 4'h0;
        energy = '0;
        cur_a = '0;
        cur_b = '0;
        cur_c = '0;
        acc_clear = 1'b0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        test_reset;
        test_regs;
        test_overcurrent;
        test_types;
        test_phases;
        test_disable;
        test_clear;
        test_derived;
        test_done;
    end

    // Whole run needs about 1200 cycles; a hang is cut well after that
    initial
    begin
        repeat (30000) @(posedge clk);
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        test_done;
    end
endmodule
